/* verilog/art_pkg.sv */
// Constants of the auto-reload timer control block: register indices,
// field positions, reset values and prescaler codes.
// Assumes a 32-bit APB bus; register byte address is four times its index.
package art_pkg;
   // ==========================================================
   // Register indices (byte address = 4 * index)
   localparam logic [7:0] ART_IDX_CTRL1 = 8'he8;
   localparam logic [7:0] ART_IDX_CTRL2 = 8'he1;
   localparam logic [7:0] ART_IDX_CTRL3 = 8'he2;
   localparam logic [7:0] ART_IDX_RLD   = 8'he9;
   localparam logic [7:0] ART_IDX_SNAP  = 8'heb;
   localparam logic [7:0] ART_IDX_CMP   = 8'hed;
   localparam logic [7:0] ART_IDX_MASK  = 8'hef;

   // ==========================================================
   // First control register fields
   localparam int ART_C1_PSC_LO  = 6;
   localparam int ART_C1_RELOAD  = 5;
   localparam int ART_C1_RUN     = 4;
   localparam int ART_C1_WRAP_IE = 3;
   localparam int ART_C1_WRAP_FL = 2;
   localparam int ART_C1_WRAP_MD = 1;

   // ==========================================================
   // Second control register fields
   localparam int ART_C2_A_ERR  = 6;
   localparam int ART_C2_B_ERR  = 5;
   localparam int ART_C2_A_IE   = 4;
   localparam int ART_C2_A_FL   = 3;
   localparam int ART_C2_A_EDGE = 2;
   localparam int ART_C2_SRC_LO = 0;

   // ==========================================================
   // Third control register fields
   localparam int ART_C3_B_EDGE = 7;
   localparam int ART_C3_B_IE   = 6;
   localparam int ART_C3_B_FL   = 5;
   localparam int ART_C3_M_IE   = 4;
   localparam int ART_C3_M_FL   = 3;
   localparam int ART_C3_Z_IE   = 2;
   localparam int ART_C3_Z_FL   = 1;
   localparam int ART_C3_W_MD   = 0;

   // ==========================================================
   // Codes and reset values
   localparam logic [1:0]  ART_PSC_OFF   = 2'h0;
   localparam logic [1:0]  ART_PSC_DIV1  = 2'h1;
   localparam logic [1:0]  ART_PSC_DIV4  = 2'h2;
   localparam logic [3:0]  ART_PRE_LIM1  = 4'h0;
   localparam logic [3:0]  ART_PRE_LIM4  = 4'h3;
   localparam logic [3:0]  ART_PRE_LIM16 = 4'hf;
   localparam logic [1:0]  ART_SRC_RUN   = 2'h0;
   localparam logic [1:0]  ART_SRC_A     = 2'h1;
   localparam logic [1:0]  ART_SRC_B     = 2'h2;
   localparam logic [1:0]  ART_SRC_OFF   = 2'h3;
   localparam logic [15:0] ART_RST_WORD  = 16'h0000;
   localparam logic [15:0] ART_WRAP_WORD = 16'hffff;
endpackage

/* verilog/art_reload_timer_unit.sv */
// Auto-reload timer control: 16-bit down counter, prescaler, two capture
// strobe inputs, masked compare/zero, wrap and wave outputs, APB registers.
// Assumes one 20 MHz clock; strobe inputs are asynchronous pins.
//
// Behaviour
// [R1] Prescale code 00 stops, else divide 1/4/16
// [R2] Software disables prescaler before changing factor
// [R3] Software sets prescale before starting counter
// [R4] Reload bit: load from reload register, else capture
// [R5] Run bit low clears and holds counter
// [R6] Each flag reaches interrupt only when enabled
// [R7] Wrap flag set by overflow, only cleared
// [R8] Wrap output follows flag or toggles per mode
// [R9] Software keeps reserved bits at zero
// [R10] Strobe A overrun flag, blocks further A events
// [R11] Strobe B overrun flag, blocks further B events
// [R12] Software clears overrun together with event flag
// [R13] Strobe A flag set by edge, only cleared
// [R14] Edge bit: 0 falling, 1 rising, per input
// [R15] Reload source: run, strobe A, strobe B, none
// [R16] Reload source leaves capture paths untouched
// [R17] Strobe B flag set with capture into snapshot
// [R18] Match flag set on masked compare, only cleared
// [R19] Zero flag set when masked counter zero, not reset
// [R20] Wave output set/reset or toggle per mode
// [R21] Match when masked counter equals masked compare
// [R22] Zero hit when masked counter equals zero
// [R23] Interrupt is OR of flag AND enable
// [R24] Flags latch regardless of interrupt enables
// [R25] Writing 0 clears a flag, writing 1 keeps it
//
// Decided for this implementation: the APB register port.
module art_reload_timer_unit
   import art_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   // Capture strobe pins
   input  wire logic              strobe_in_a,
   input  wire logic              strobe_in_b,
   // Timer outputs
   output      logic              wrap_out_pin,
   output      logic              wave_out_pin,
   output      logic              timer_irq
);
   import art_pkg::*;

   // The highest register byte address needs ten address bits
   if (ADDR_W < 10) begin : g_addr_chk
      $error("ADDR_W too small for the register map");
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic [1:0]  psc;
      logic        reload_en;
      logic        run;
      logic        wrap_ie;
      logic        wrap_flag;
      logic        wrap_style;
      logic        a_err;
      logic        b_err;
      logic        a_ie;
      logic        a_flag;
      logic        a_edge;
      logic [1:0]  rsrc;
      logic        b_edge;
      logic        b_ie;
      logic        b_flag;
      logic        m_ie;
      logic        m_flag;
      logic        z_ie;
      logic        z_flag;
      logic        w_style;
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [15:0] snap;
      logic [15:0] cmp;
      logic [15:0] msk;
      logic [3:0]  pre;
      logic [2:0]  sa;
      logic [2:0]  sb;
      logic        la;
      logic        lb;
      logic        mprev;
      logic        zprev;
      logic        wrap_o;
      logic        wave_o;
      logic [31:0] rdata;
   } art_state_t;

   art_state_t st_reg;
   art_state_t st_next;

   // ==========================================================
   // Helpers
   // Limit is the division factor minus one
   function automatic logic [3:0] pre_limit(input logic [1:0] code);
      if (code == ART_PSC_DIV4) begin
         pre_limit = ART_PRE_LIM4;
      end else if (code == ART_PSC_DIV1) begin
         pre_limit = ART_PRE_LIM1;
      end else begin
         pre_limit = ART_PRE_LIM16;
      end
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   function automatic logic masked_eq(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] m);
      masked_eq = ((a & m) == (b & m));
   endfunction

   logic       mapped;
   logic       wr;
   logic       wr1;
   logic       wr2;
   logic       wr3;
   logic [7:0] rd1;
   logic [7:0] rd2;
   logic [7:0] rd3;

   assign mapped = hit(paddr, ART_IDX_CTRL1) | hit(paddr, ART_IDX_CTRL2) |
                   hit(paddr, ART_IDX_CTRL3) | hit(paddr, ART_IDX_RLD) |
                   hit(paddr, ART_IDX_SNAP) | hit(paddr, ART_IDX_CMP) |
                   hit(paddr, ART_IDX_MASK);
   assign wr  = psel & penable & pwrite & mapped;
   assign wr1 = wr & hit(paddr, ART_IDX_CTRL1);
   assign wr2 = wr & hit(paddr, ART_IDX_CTRL2);
   assign wr3 = wr & hit(paddr, ART_IDX_CTRL3);

   // Reserved bits read back as zero
   assign rd1 = {st_reg.psc, st_reg.reload_en, st_reg.run, st_reg.wrap_ie,
                 st_reg.wrap_flag, st_reg.wrap_style, 1'b0};
   assign rd2 = {1'b0, st_reg.a_err, st_reg.b_err, st_reg.a_ie, st_reg.a_flag,
                 st_reg.a_edge, st_reg.rsrc};
   assign rd3 = {st_reg.b_edge, st_reg.b_ie, st_reg.b_flag, st_reg.m_ie,
                 st_reg.m_flag, st_reg.z_ie, st_reg.z_flag, st_reg.w_style};

   // ==========================================================
   // Next state
   always_comb begin
      logic tick;
      logic ovf;
      logic run_rise;
      logic na;
      logic nb;
      logic ev_a;
      logic ev_b;
      logic mcond;
      logic zcond;
      logic m_ev;
      logic z_ev;
      tick     = 1'b0;
      ovf      = 1'b0;
      run_rise = 1'b0;
      ev_a     = 1'b0;
      ev_b     = 1'b0;
      na       = 1'b0;
      nb       = 1'b0;
      mcond    = 1'b0;
      zcond    = 1'b0;
      m_ev     = 1'b0;
      z_ev     = 1'b0;
      st_next  = st_reg;

      // Read data latched in the setup phase, so it is a flop at access
      if (psel & ~penable) begin
         if (hit(paddr, ART_IDX_CTRL1)) begin
            st_next.rdata = {24'h0, rd1};
         end else if (hit(paddr, ART_IDX_CTRL2)) begin
            st_next.rdata = {24'h0, rd2};
         end else if (hit(paddr, ART_IDX_CTRL3)) begin
            st_next.rdata = {24'h0, rd3};
         end else if (hit(paddr, ART_IDX_RLD)) begin
            st_next.rdata = {16'h0, st_reg.rld};
         end else if (hit(paddr, ART_IDX_SNAP)) begin
            st_next.rdata = {16'h0, st_reg.snap};
         end else if (hit(paddr, ART_IDX_CMP)) begin
            st_next.rdata = {16'h0, st_reg.cmp};
         end else if (hit(paddr, ART_IDX_MASK)) begin
            st_next.rdata = {16'h0, st_reg.msk};
         end else begin
            st_next.rdata = 32'h0;
         end
      end

      // Software writes; flags only clear on a written 0
      if (wr1) begin
         st_next.psc        = pwdata[ART_C1_PSC_LO +: 2];
         st_next.reload_en  = pwdata[ART_C1_RELOAD];
         st_next.run        = pwdata[ART_C1_RUN];
         st_next.wrap_ie    = pwdata[ART_C1_WRAP_IE];
         st_next.wrap_flag  = st_reg.wrap_flag & pwdata[ART_C1_WRAP_FL]; // R25
         st_next.wrap_style = pwdata[ART_C1_WRAP_MD];
      end
      if (wr2) begin
         st_next.a_err  = st_reg.a_err & pwdata[ART_C2_A_ERR]; // R25
         st_next.b_err  = st_reg.b_err & pwdata[ART_C2_B_ERR];
         st_next.a_ie   = pwdata[ART_C2_A_IE];
         st_next.a_flag = st_reg.a_flag & pwdata[ART_C2_A_FL];
         st_next.a_edge = pwdata[ART_C2_A_EDGE];
         st_next.rsrc   = pwdata[ART_C2_SRC_LO +: 2];
      end
      if (wr3) begin
         st_next.b_edge  = pwdata[ART_C3_B_EDGE];
         st_next.b_ie    = pwdata[ART_C3_B_IE];
         st_next.b_flag  = st_reg.b_flag & pwdata[ART_C3_B_FL]; // R25
         st_next.m_ie    = pwdata[ART_C3_M_IE];
         st_next.m_flag  = st_reg.m_flag & pwdata[ART_C3_M_FL];
         st_next.z_ie    = pwdata[ART_C3_Z_IE];
         st_next.z_flag  = st_reg.z_flag & pwdata[ART_C3_Z_FL];
         st_next.w_style = pwdata[ART_C3_W_MD];
      end
      // Reload word is a capture target while reload is off
      if (wr & hit(paddr, ART_IDX_RLD) & st_reg.reload_en) begin
         st_next.rld = pwdata[15:0];
      end
      if (wr & hit(paddr, ART_IDX_CMP)) begin
         st_next.cmp = pwdata[15:0];
      end
      if (wr & hit(paddr, ART_IDX_MASK)) begin
         st_next.msk = pwdata[15:0];
      end

      // Strobe pins: three flops, level accepted when 2nd and 3rd agree
      // The first flop may go metastable; only the later two are compared
      st_next.sa = {st_reg.sa[1:0], strobe_in_a};
      st_next.sb = {st_reg.sb[1:0], strobe_in_b};
      na = (st_reg.sa[2] == st_reg.sa[1]) ? st_reg.sa[2] : st_reg.la;
      nb = (st_reg.sb[2] == st_reg.sb[1]) ? st_reg.sb[2] : st_reg.lb;
      st_next.la = na;
      st_next.lb = nb;
      if (st_reg.run) begin // R5
         ev_a = (na != st_reg.la) & (na == st_reg.a_edge); // R14
         ev_b = (nb != st_reg.lb) & (nb == st_reg.b_edge); // R14
      end

      // Prescaler
      // A factor change while running may cut one period short;
      // software stops the prescaler first to avoid it
      if (~st_reg.run | (st_reg.psc == ART_PSC_OFF)) begin
         st_next.pre = 4'h0; // R1
      end else if (st_reg.pre >= pre_limit(st_reg.psc)) begin
         st_next.pre = 4'h0;
         tick = 1'b1; // R1
      end else begin
         st_next.pre = st_reg.pre + 4'h1;
      end

      // Capture paths are the same whatever the reload source
      if (ev_a & ~st_reg.a_err) begin // R16
         if (st_reg.a_flag) begin
            st_next.a_err = 1'b1; // R10
         end else begin
            st_next.a_flag = 1'b1; // R13
            if (~st_reg.reload_en) begin
               st_next.rld = st_reg.cnt; // R4
            end
         end
      end
      if (ev_b & ~st_reg.b_err) begin
         if (st_reg.b_flag) begin
            st_next.b_err = 1'b1; // R11
         end else begin
            st_next.b_flag = 1'b1; // R17
            st_next.snap   = st_reg.cnt; // R17
         end
      end

      // Counter; capture above used the old value, so capture precedes reload
      run_rise = st_next.run & ~st_reg.run;
      if (~st_reg.run) begin
         st_next.cnt = ART_RST_WORD; // R5
      end else begin
         if (tick) begin
            if (st_reg.cnt == ART_RST_WORD) begin
               ovf = 1'b1;
               if (st_reg.reload_en & (st_reg.rsrc != ART_SRC_OFF)) begin
                  st_next.cnt = st_reg.rld; // R4
               end else begin
                  // No reload: free running wrap to the all-ones word
                  st_next.cnt = ART_WRAP_WORD;
               end
            end else begin
               st_next.cnt = st_reg.cnt - 16'h1;
            end
         end
         // Strobe reloads happen on every selected edge, flags or not
         if (st_reg.reload_en & ((ev_a & (st_reg.rsrc == ART_SRC_A)) |
                                 (ev_b & (st_reg.rsrc == ART_SRC_B)))) begin
            st_next.cnt = st_reg.rld; // R15
         end
      end
      // Start by the run bit loads the reload word in the same edge
      if (run_rise & st_reg.reload_en & (st_reg.rsrc == ART_SRC_RUN)) begin
         st_next.cnt = st_reg.rld; // R15
      end

      // Masked compare and zero, edge-detected so a held value fires once
      mcond = st_reg.run & masked_eq(st_reg.cnt, st_reg.cmp, st_reg.msk); // R21
      // Run low is the held-reset state, so its forced zero only counts after run is set, unless the start reloads
      zcond = st_reg.run & masked_eq(st_reg.cnt, ART_RST_WORD, st_reg.msk); // R22 R19
      st_next.mprev = mcond;
      st_next.zprev = zcond;
      m_ev = mcond & ~st_reg.mprev;
      z_ev = zcond & ~st_reg.zprev;

      // Hardware sets last so a set beats a clear in the same cycle
      if (ovf) begin
         st_next.wrap_flag = 1'b1; // R7 R24
      end
      if (m_ev) begin
         st_next.m_flag = 1'b1; // R18
      end
      if (z_ev) begin
         st_next.z_flag = 1'b1; // R19
      end

      // Wrap output
      // Set style: the pin falls on the same edge as the flag when software clears it
      if (st_reg.wrap_style) begin
         st_next.wrap_o = st_reg.wrap_o ^ ovf; // R8
      end else begin
         st_next.wrap_o = (st_reg.wrap_o | ovf) & st_next.wrap_flag; // R8
      end

      // Wave output; in set/reset a coincident compare wins
      if (st_reg.w_style) begin
         st_next.wave_o = st_reg.wave_o ^ m_ev; // R20
      end else if (m_ev) begin
         st_next.wave_o = 1'b0; // R20
      end else if (z_ev) begin
         st_next.wave_o = 1'b1; // R20
      end
   end

   // ==========================================================
   // Register
   // Synchronous reset; prescale off is named so the stopped state is explicit
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_reg     <= '0;
         st_reg.psc <= ART_PSC_OFF; // R2
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign prdata       = st_reg.rdata;
   // Every register answers at once, so no wait state is ever inserted
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~mapped;
   assign wrap_out_pin = st_reg.wrap_o;
   assign wave_out_pin = st_reg.wave_o;
   assign timer_irq    = (st_reg.a_flag & st_reg.a_ie) | (st_reg.b_flag & st_reg.b_ie) |
                         (st_reg.wrap_flag & st_reg.wrap_ie) |
                         (st_reg.m_flag & st_reg.m_ie) |
                         (st_reg.z_flag & st_reg.z_ie); // R6 R23
endmodule

/* sim/art_assertions.sv */
// Checker for the timer control block, bound to its top module.
// Assumes zero wait-state APB; byte address is four times the index.
module art_assertions
   import art_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic              clock,
   input wire logic              nrst,
   // APB
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Pins
   input wire logic              strobe_in_a,
   input wire logic              strobe_in_b,
   input wire logic              wrap_out_pin,
   input wire logic              wave_out_pin,
   input wire logic              timer_irq
);
   // ==========================================
   // Shadow of the first control register
   logic [7:0]        c1_reg;
   logic [ADDR_W-3:0] word;
   logic              acc;
   logic              rd;
   logic              idle;
   logic              mapped;
   assign acc = psel && penable;
   assign rd = acc && !pwrite;
   assign word = paddr[ADDR_W-1:2];
   assign mapped = paddr[1:0] == 2'h0 && word inside {ART_IDX_CTRL1, ART_IDX_CTRL2,
      ART_IDX_CTRL3, ART_IDX_RLD, ART_IDX_SNAP, ART_IDX_CMP, ART_IDX_MASK};
   // Toggle style with no counting: nothing may move the wrap pin
   assign idle = c1_reg[1] && (!c1_reg[4] || c1_reg[7:6] == ART_PSC_OFF);
   always_ff @(posedge clock) begin
      if (!nrst)
         c1_reg <= 8'h00;
      else if (acc && pwrite && word == ART_IDX_CTRL1)
         c1_reg <= pwdata[7:0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   property p_map; pslverr == (acc && !mapped); endproperty
   a_map: assert property (p_map) else $error("pslverr wrong");
   property p_upper; rd |-> prdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_irq1; rd && word == ART_IDX_CTRL1 && prdata[3] && prdata[2] |-> timer_irq;
   endproperty
   a_irq1: assert property (p_irq1) else $error("wrap irq missing");
   property p_irq3; rd && word == ART_IDX_CTRL3 && (prdata[6] && prdata[5]
      || prdata[4] && prdata[3] || prdata[2] && prdata[1]) |-> timer_irq; endproperty
   a_irq3: assert property (p_irq3) else $error("ctrl3 irq missing");
   property p_wave_hold;
      !c1_reg[4] && !$past(c1_reg[4]) && !$past(c1_reg[4], 2) |-> $stable(wave_out_pin);
   endproperty
   a_wave_hold: assert property (p_wave_hold) else $error("wave moved on hold");
   property p_wrap_stop; idle && $past(idle) && $past(idle, 2) |-> $stable(wrap_out_pin);
   endproperty
   a_wrap_stop: assert property (p_wrap_stop) else $error("wrap moved stopped");
   // Run already off, so no overflow can set the flag at the clearing write
   property p_wrap_drop; acc && pwrite && word == ART_IDX_CTRL1 && pwdata[4:1] == 4'h0
      && !c1_reg[4] |-> ##2 !wrap_out_pin; endproperty
   a_wrap_drop: assert property (p_wrap_drop) else $error("wrap not dropped");
   c_err: cover property (pslverr);
   c_irq: cover property ($rose(timer_irq));
   c_wave: cover property ($rose(wave_out_pin));
endmodule

bind art_reload_timer_unit art_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .strobe_in_a(strobe_in_a), .strobe_in_b(strobe_in_b),
   .wrap_out_pin(wrap_out_pin), .wave_out_pin(wave_out_pin), .timer_irq(timer_irq));

/* sim/art_strobe_src.sv */
// Model of the two capture sources driving the strobe pins.
// Assumes calls come right after a rising edge of the timer clock.
module art_strobe_src (
   // Clock
   input  wire logic clock,
   // Strobe pins
   output      logic strobe_in_a,
   output      logic strobe_in_b
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Pins idle low
   initial begin
      strobe_in_a = 1'b0;
      strobe_in_b = 1'b0;
   end
   // Level held well past the synchroniser and event latency
   task automatic set_pin(input logic b, input logic lvl);
      @(posedge clock);
      if (b)
         strobe_in_b <= lvl;
      else
         strobe_in_a <= lvl;
      repeat (7) @(posedge clock);
   endtask
endmodule

/* sim/tb.sv */
// Self-checking bench of the timer control block over APB.
// Assumes the strobe model and the bound checker.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import art_pkg::*;
   localparam logic [7:0] C1 = ART_IDX_CTRL1;
   localparam logic [7:0] C2 = ART_IDX_CTRL2;
   localparam logic [7:0] C3 = ART_IDX_CTRL3;
   logic        clock;
   logic        nrst;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        strobe_in_a;
   logic        strobe_in_b;
   logic        wrap_out_pin;
   logic        wave_out_pin;
   logic        timer_irq;
   logic [31:0] rdat;
   logic        rerr;
   int          fail_count;
   int          n_checks;
   int          n;
   int          e;
   art_reload_timer_unit #(.ADDR_W(12)) u_dut (.clock(clock), .nrst(nrst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobe_in_a(strobe_in_a),
      .strobe_in_b(strobe_in_b), .wrap_out_pin(wrap_out_pin),
      .wave_out_pin(wave_out_pin), .timer_irq(timer_irq));
   art_strobe_src u_src (.clock(clock), .strobe_in_a(strobe_in_a),
      .strobe_in_b(strobe_in_b));
   // ==========================================
   // Clock, tasks, watchdog
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Idle edge first, so psel never changes twice in one step
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(idx, 1'b1, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
      apb(idx, 1'b0, 32'h0);
      check(nm, rdat, exp);
   endtask
   task automatic gap(input logic w, output int c);
      logic p;
      p = w ? wave_out_pin : wrap_out_pin;
      c = 0;
      while ((w ? wave_out_pin : wrap_out_pin) === p && c < 3000) begin
         @(posedge clock);
         c++;
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      $display("watchdog expired");
      summarize();
   end
   // ==========================================
   // Tests
   initial begin
      fail_count = 0;
      n_checks = 0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      rdc("ctrl1", C1, 32'h0);
      rdc("ctrl2", C2, 32'h0);
      rdc("ctrl3", C3, 32'h0);
      apb(8'h00, 1'b0, 32'h0);
      check("unmapped err", {31'h0, rerr}, 32'h1);
      check("unmapped data", rdat, 32'h0);
      wr(C1, 32'h0c);
      rdc("ctrl1 ones", C1, 32'h08);
      wr(C2, 32'h7c);
      rdc("ctrl2 ones", C2, 32'h14);
      wr(C3, 32'hff);
      rdc("ctrl3 ones", C3, 32'hd5);
      check("irq no flag", {31'h0, timer_irq}, 32'h0);
      $display("test registers done");
      wr(C2, 32'h00);
      wr(C3, 32'h00);
      wr(C1, 32'h20);
      wr(ART_IDX_RLD, 32'h3);
      for (int c = 1; c < 4; c++) begin
         wr(C1, 32'h22);
         wr(C1, 32'h22 | c << 6);
         wr(C1, 32'h32 | c << 6);
         gap(1'b0, n);
         gap(1'b0, n);
         check("wrap period", 32'(n), 32'(4 << (2 * (c - 1))));
      end
      wr(C1, 32'h20);
      wr(C1, 32'h60);
      wr(C1, 32'h70);
      repeat (20) @(posedge clock);
      wr(C1, 32'h64);
      rdc("wrap flag", C1, 32'h64);
      repeat (10) @(posedge clock);
      check("wrap held", {31'h0, wrap_out_pin}, 32'h1);
      check("irq masked", {31'h0, timer_irq}, 32'h0);
      wr(C1, 32'h6c);
      @(posedge clock);
      check("irq on", {31'h0, timer_irq}, 32'h1);
      rdc("ctrl1 ie", C1, 32'h6c);
      wr(C1, 32'h68);
      repeat (2) @(posedge clock);
      check("wrap drop", {31'h0, wrap_out_pin}, 32'h0);
      check("irq drop", {31'h0, timer_irq}, 32'h0);
      $display("test prescale and wrap done");
      wr(C1, 32'h40);
      u_src.set_pin(1'b0, 1'b1);
      u_src.set_pin(1'b0, 1'b0);
      rdc("held no event", C2, 32'h0);
      wr(C1, 32'h50);
      for (int k = 0; k < 2; k++) begin
         e = 0;
         wr(C2, k == 0 ? 32'h04 : 32'h00);
         for (int j = 0; j < 4; j++) begin
            u_src.set_pin(k[0], j % 2 == 0);
            e += int'((j % 2 == 0) == (k == 0));
            rdc("capt ctrl2", C2, k == 0 ? 32'h04 | (e > 1 ? 32'h40 : 32'h0) |
               (e > 0 ? 32'h08 : 32'h0) : (e > 1 ? 32'h20 : 32'h0));
            apb(C3, 1'b0, 32'h0);
            check("capt ctrl3", rdat & 32'ha0, k == 1 && e > 0 ? 32'h20 : 32'h0);
         end
         wr(C2, k == 0 ? 32'h04 : 32'h00);
         wr(C3, 32'h0);
         rdc("capt clear", C2, k == 0 ? 32'h04 : 32'h00);
      end
      $display("test capture done");
      wr(C1, 32'h00);
      wr(ART_IDX_MASK, 32'h3);
      wr(ART_IDX_CMP, 32'h1);
      wr(C3, 32'h01);
      wr(C1, 32'h40);
      wr(C1, 32'h50);
      gap(1'b1, n);
      gap(1'b1, n);
      check("wave period", 32'(n), 32'h4);
      apb(C3, 1'b0, 32'h0);
      check("match zero", rdat & 32'h0a, 32'h0a);
      wr(C3, 32'h11);
      repeat (8) @(posedge clock);
      check("irq match", {31'h0, timer_irq}, 32'h1);
      apb(C3, 1'b0, 32'h0);
      check("match ie", rdat & 32'h18, 32'h18);
      $display("test wave done");
      wr(C1, 32'h00);
      wr(C1, 32'h20);
      wr(ART_IDX_RLD, 32'h5);
      wr(ART_IDX_MASK, 32'hffff);
      wr(ART_IDX_CMP, 32'h5);
      wr(C2, 32'h05);
      wr(C3, 32'h00);
      wr(C1, 32'h30);
      apb(C3, 1'b0, 32'h0);
      check("zero on hold", rdat & 32'h0a, 32'h02);
      check("wave set", {31'h0, wave_out_pin}, 32'h1);
      u_src.set_pin(1'b0, 1'b1);
      apb(C3, 1'b0, 32'h0);
      check("strobe reload", rdat & 32'h0a, 32'h0a);
      check("wave reset", {31'h0, wave_out_pin}, 32'h0);
      rdc("reload flag", C2, 32'h0d);
      u_src.set_pin(1'b1, 1'b1);
      u_src.set_pin(1'b1, 1'b0);
      rdc("snapshot", ART_IDX_SNAP, 32'h5);
      rdc("reload kept", ART_IDX_RLD, 32'h5);
      $display("test strobe reload done");
      summarize();
   end
endmodule
